//--- bench/dmc_channel_tb.sv
/*
  Self-checking bench of the debug message channel.
  Assumes the channel at 8'h31 with a shared address.
*/
`timescale 1ns/1ps
module dmc_channel_tb;
  import dmc_pkg::*;
  logic clock_i = 0, rst_n_i = 0, wr = 0, rd = 0, ers = 0, fprog = 0, fval = 0;
  logic lk1 = 0, lk2 = 0, auto = 0, en = 0, mflag = 0, mfuse = 0;
  logic [1:0] lat = 0;
  dmc_addr_t addr = 0;
  dmc_byte_t wdata = 0, srd = 0, mdat = 0, d, rdata, swd, dbgd, got;
  logic rvalid, swr, srd_o, dirty, clr, acc, refused, fuse;
  int error_cnt = 0, compares = 0, cyc = 0;
  logic [31:0] seed = 32'h2EDF9079;
  always #2 clock_i = ~clock_i;
  dmc_channel i_dmc_channel (.clock_i(clock_i), .rst_n_i(rst_n_i), .cpu_addr_i(addr),
    .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .cpu_rvalid_o(rvalid), .std_io_wr_o(swr), .std_io_rd_o(srd_o), .std_io_wdata_o(swd),
    .std_io_rdata_i(srd), .dbg_access_en_i(acc), .dbg_clear_i(clr), .dbg_data_o(dbgd),
    .debug_data_dirty_flag_o(dirty), .lock_bit_one_i(lk1), .lock_bit_two_i(lk2),
    .chip_erase_i(ers), .fuse_prog_i(fprog), .fuse_value_i(fval),
    .fuse_refused_o(refused), .debug_enable_fuse_o(fuse));
  dmc_dbg_model i_dmc_dbg_model (.clock_i(clock_i), .auto_i(auto), .lat_i(lat),
    .en_req_i(en), .data_i(dbgd), .dirty_i(dirty), .access_en_o(acc), .clear_o(clr),
    .got_o(got));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // one cpu access at the shared address
  task automatic cpu(logic w, dmc_byte_t dt, logic routed);
    @(negedge clock_i);
    addr = 8'h31;
    wdata = dt;
    srd = 8'(rnd());
    wr = w;
    rd = !w;
    #1 chk(w ? swr : srd_o, !routed);
    if (w) chk(swd, dt);
    @(negedge clock_i);
    wr = 0;
    rd = 0;
    if (w && routed) begin
      mdat = dt;
      mflag = 1;
    end
    if (w) chk({dbgd, dirty}, {mdat, mflag});
    else chk({rvalid, rdata}, {1'b1, routed ? {mflag, mdat[6:0]} : srd});
  endtask
  // access at another address: nothing may react
  task automatic miss(logic w);
    @(negedge clock_i);
    addr = 8'(rnd());
    if (addr == 8'h31) addr = 8'h30;
    wdata = 8'(rnd());
    wr = w;
    rd = !w;
    #1 chk({swr, srd_o}, 0);
    @(negedge clock_i);
    wr = 0;
    rd = 0;
    chk({rvalid, dbgd, dirty}, {1'b0, mdat, mflag});
  endtask
  // fuse program request
  task automatic fprg(logic v, logic ref_exp);
    @(negedge clock_i);
    fprog = 1;
    fval = v;
    @(negedge clock_i);
    fprog = 0;
    if (!ref_exp) mfuse = v;
    chk({refused, fuse}, {ref_exp, mfuse});
  endtask
  always @(posedge clock_i) begin
    if (++cyc == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clock_i);
    @(negedge clock_i) rst_n_i = 1;
    chk({dbgd, dirty, fuse, rvalid}, 0);
    en = 1;
    cpu(1, 8'h5A, 0);
    cpu(0, 8'h00, 0);
    for (int i = 1; i < 4; i++) begin
      @(negedge clock_i) {lk2, lk1} = i[1:0];
      fprg(1, 1);
      @(negedge clock_i) ers = 1;
      @(negedge clock_i) ers = 0;
      fprg(1, 0);
      @(negedge clock_i) {lk2, lk1} = 2'h0;
      fprg(0, 0);
    end
    @(negedge clock_i) lk1 = 1;
    @(negedge clock_i) {ers, fprog, fval} = 3'h7;
    @(negedge clock_i) {ers, fprog} = 2'h0;
    chk({refused, fuse}, {1'b1, mfuse});
    fprg(1, 0);
    @(negedge clock_i) lk1 = 0;
    fprg(1, 0);
    for (int n = 0; n < 20; n++) begin
      d = (n == 0) ? 8'hFF : rnd();
      lat = 2'(rnd());
      cpu(1, d, 1);
      miss(n[0]);
      cpu(0, 8'h00, 1);
      auto = 1;
      repeat (10) if (dirty) @(negedge clock_i);
      auto = 0;
      mflag = 0;
      chk({got, dirty}, {d, 1'b0});
      cpu(0, 8'h00, 1);
    end
    lat = 2'h0;
    auto = 1;
    cpu(1, 8'hA5, 1);
    cpu(1, 8'h5A, 1);
    repeat (10) if (dirty) @(negedge clock_i);
    auto = 0;
    mflag = 0;
    chk({got, dirty}, {8'h5A, 1'b0});
    en = 0;
    cpu(1, 8'h3C, 0);
    cpu(0, 8'h00, 0);
    give_verdict();
  end
endmodule

//--- bench/dmc_dbg_model.sv
/*
  External debugger model: once the dirty flag is up it waits lat_i
  cycles, takes the stored byte and pulses the clear.
  Assumes the bench drives auto_i, lat_i and en_req_i at the falling edge.
*/
`timescale 1ns/1ps
module dmc_dbg_model (
  input  wire logic               clock_i,
  input  wire logic               auto_i,
  input  wire logic [1:0]         lat_i,
  input  wire logic               en_req_i,
  input  wire dmc_pkg::dmc_byte_t data_i,
  input  wire logic               dirty_i,
  output logic                    access_en_o,
  output logic                    clear_o,
  output dmc_pkg::dmc_byte_t      got_o
);
  import dmc_pkg::*;
  logic [1:0] wait_ff  = 2'h0;
  logic       clear_ff = 1'b0;
  dmc_byte_t  got_ff   = 8'h00;
  assign access_en_o = en_req_i;
  assign clear_o     = clear_ff;
  assign got_o       = got_ff;
  always @(posedge clock_i) begin
    if (auto_i && dirty_i && !clear_ff && wait_ff == lat_i) begin
      got_ff <= data_i;
      clear_ff <= 1'b1;
      wait_ff <= 2'h0;
    end else begin
      clear_ff <= 1'b0;
      if (auto_i && dirty_i && !clear_ff) wait_ff <= wait_ff + 2'h1;
    end
  end
endmodule

//--- hw/dmc_channel.sv
/*
  Debug message channel: byte register written by the cpu, read back
  with a dirty flag, cleared by the external debugger; address shared
  with an ordinary i/o register under fuse and debugger control.
  Assumes cpu strobes are one-cycle pulses synchronous to clock_i and
  that the ordinary register answers std_io_rdata_i in the strobe cycle.

// Summary of operation
// [RQ1] byte register carries program messages to debugger
// [RQ2] cpu write sets dirty flag bit 7
// [RQ3] read returns seven data bits plus flag
// [RQ4] debugger clears flag after reading byte
// [RQ5] shared address reaches channel only when enabled
// [RQ6] otherwise shared address reaches ordinary register
// [RQ7] locked part refuses fuse program until erase
*/
`timescale 1ns/1ps
`include "dmc_regs.svh"

module dmc_channel (
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // cpu i/o port
  input  wire dmc_pkg::dmc_addr_t cpu_addr_i,
  input  wire logic              cpu_wr_i,
  input  wire logic              cpu_rd_i,
  input  wire dmc_pkg::dmc_byte_t cpu_wdata_i,
  output dmc_pkg::dmc_byte_t     cpu_rdata_o,
  output logic                   cpu_rvalid_o,
  // ordinary i/o register sharing the address
  output logic                   std_io_wr_o,
  output logic                   std_io_rd_o,
  output dmc_pkg::dmc_byte_t     std_io_wdata_o,
  input  wire dmc_pkg::dmc_byte_t std_io_rdata_i,
  // debugger side
  input  wire logic              dbg_access_en_i,
  input  wire logic              dbg_clear_i,
  output dmc_pkg::dmc_byte_t     dbg_data_o,
  output logic                   debug_data_dirty_flag_o,
  // fuse and lock bits
  input  wire logic              lock_bit_one_i,
  input  wire logic              lock_bit_two_i,
  input  wire logic              chip_erase_i,
  input  wire logic              fuse_prog_i,
  input  wire logic              fuse_value_i,
  output logic                   fuse_refused_o,
  output logic                   debug_enable_fuse_o
);
  import dmc_pkg::*;

  dmc_byte_t chan_ff;
  logic      dirty_ff;
  dmc_byte_t rdata_ff;
  logic      rvalid_ff;
  logic      fuse;
  logic      addr_hit;
  logic      route_chan;
  logic      chan_wr;
  logic      chan_rd;
  logic      std_wr;
  logic      std_rd;

  // read value: seven stored bits under the dirty flag
  function automatic dmc_byte_t read_value(input dmc_byte_t data, input logic dirty);
    read_value = {dirty, data[`DMC_DATA_MSB:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // fuse store and lock interlock
  dmc_fuse_guard u_fuse_guard (
    .clock_i             (clock_i),
    .rst_n_i             (rst_n_i),
    .lock_bit_one_i      (lock_bit_one_i),
    .lock_bit_two_i      (lock_bit_two_i),
    .chip_erase_i        (chip_erase_i),
    .fuse_prog_i         (fuse_prog_i),
    .fuse_value_i        (fuse_value_i),
    .fuse_refused_o      (fuse_refused_o),
    .debug_enable_fuse_o (fuse)
  );

  assign debug_enable_fuse_o = fuse;

  ////////////////////////////////////////////////////////////////////
  // address routing
  assign addr_hit   = (cpu_addr_i == `DMC_CHAN_ADDR);
  assign route_chan = ~`DMC_ADDR_SHARED | (fuse & dbg_access_en_i); // RQ5
  assign chan_wr    = cpu_wr_i & addr_hit & route_chan; // RQ5
  assign chan_rd    = cpu_rd_i & addr_hit & route_chan;
  assign std_wr     = cpu_wr_i & addr_hit & ~route_chan; // RQ6
  assign std_rd     = cpu_rd_i & addr_hit & ~route_chan; // RQ6

  assign std_io_wr_o    = std_wr;
  assign std_io_rd_o    = std_rd;
  assign std_io_wdata_o = cpu_wdata_i;

  ////////////////////////////////////////////////////////////////////
  // channel byte
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      chan_ff <= `DMC_CHAN_RESET;
    end else if (chan_wr) begin
      chan_ff <= cpu_wdata_i; // RQ1
    end
  end

  // dirty flag: a cpu write in the clear cycle wins
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dirty_ff <= `DMC_DIRTY_RESET;
    end else if (chan_wr) begin
      dirty_ff <= 1'b1; // RQ2
    end else if (dbg_clear_i) begin
      dirty_ff <= 1'b0; // RQ4
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cpu read answer, one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_ff <= 8'h00;
    end else if (chan_rd) begin
      rdata_ff <= read_value(chan_ff, dirty_ff); // RQ3
    end else if (std_rd) begin
      rdata_ff <= std_io_rdata_i; // RQ6
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= chan_rd | std_rd;
    end
  end

  assign cpu_rdata_o             = rdata_ff;
  assign cpu_rvalid_o            = rvalid_ff;
  assign dbg_data_o              = chan_ff;
  assign debug_data_dirty_flag_o = dirty_ff;

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_data_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      !chan_wr |=> $stable(chan_ff);
  endproperty
  a_data_hold: assert property (p_data_hold) // RQ1
    else $error("channel byte changed without a cpu write");

  property p_wr_sets_dirty;
    @(posedge clock_i) disable iff (!rst_n_i)
      chan_wr |=> dirty_ff && chan_ff == $past(cpu_wdata_i);
  endproperty
  a_wr_sets_dirty: assert property (p_wr_sets_dirty) // RQ2
    else $error("cpu write did not store byte and set dirty");

  property p_rd_format;
    @(posedge clock_i) disable iff (!rst_n_i)
      chan_rd |=> cpu_rvalid_o
        && cpu_rdata_o[`DMC_DIRTY_BIT] == $past(dirty_ff)
        && cpu_rdata_o[`DMC_DATA_MSB:0] == $past(chan_ff[`DMC_DATA_MSB:0]);
  endproperty
  a_rd_format: assert property (p_rd_format) // RQ3
    else $error("channel read value wrong");

  property p_clear;
    @(posedge clock_i) disable iff (!rst_n_i)
      dbg_clear_i && !chan_wr |=> !dirty_ff;
  endproperty
  a_clear: assert property (p_clear) // RQ4
    else $error("debugger clear not honoured");

  property p_route_chan;
    @(posedge clock_i) disable iff (!rst_n_i)
      cpu_wr_i && addr_hit && fuse && dbg_access_en_i |-> !std_io_wr_o ##1 dirty_ff;
  endproperty
  a_route_chan: assert property (p_route_chan) // RQ5
    else $error("enabled access did not reach channel");

  property p_route_std;
    @(posedge clock_i) disable iff (!rst_n_i)
      cpu_wr_i && addr_hit && !(fuse && dbg_access_en_i)
      |-> std_io_wr_o ##1 $stable(chan_ff);
  endproperty
  a_route_std: assert property (p_route_std) // RQ6
    else $error("disabled access not sent to ordinary register");

  // read answer, address decode and dirty flag rise
  property p_rvalid_on_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      !(chan_rd || std_rd) |=> !cpu_rvalid_o;
  endproperty
  a_rvalid_on_read: assert property (p_rvalid_on_read) // RQ3
    else $error("read answer flagged without a read strobe");

  property p_rdata_hold;
    @(posedge clock_i) disable iff (!rst_n_i)
      !(chan_rd || std_rd) |=> $stable(cpu_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) // RQ3
    else $error("read data changed without a read strobe");

  property p_std_read;
    @(posedge clock_i) disable iff (!rst_n_i)
      std_rd |=> cpu_rvalid_o && cpu_rdata_o == $past(std_io_rdata_i);
  endproperty
  a_std_read: assert property (p_std_read) // RQ6
    else $error("ordinary register read not returned");

  property p_miss_ignored;
    @(posedge clock_i) disable iff (!rst_n_i)
      (cpu_wr_i || cpu_rd_i) && !addr_hit
      |-> !std_io_wr_o && !std_io_rd_o ##1 !cpu_rvalid_o && $stable(chan_ff);
  endproperty
  a_miss_ignored: assert property (p_miss_ignored) // RQ6
    else $error("access at another address was acted on");

  property p_dirty_rise;
    @(posedge clock_i) disable iff (!rst_n_i)
      !chan_wr |=> !$rose(dirty_ff);
  endproperty
  a_dirty_rise: assert property (p_dirty_rise) // RQ2
    else $error("dirty flag set without a cpu write");

endmodule

//--- hw/dmc_fuse_guard.sv
/*
  Debug enable fuse store with lock-bit interlock.
  Assumes lock bit inputs are high while programmed and that chip
  erase is a one-cycle pulse from the programming logic.
*/
`timescale 1ns/1ps
`include "dmc_regs.svh"

module dmc_fuse_guard (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic lock_bit_one_i,
  input  wire logic lock_bit_two_i,
  input  wire logic chip_erase_i,
  input  wire logic fuse_prog_i,
  input  wire logic fuse_value_i,
  output logic      fuse_refused_o,
  output logic      debug_enable_fuse_o
);
  import dmc_pkg::*;

  logic locked;
  logic lock_prev_ff;
  logic erased_ff;
  logic fuse_ff;
  logic refused_ff;
  logic prog_ok;

  assign locked  = lock_bit_one_i | lock_bit_two_i;
  assign prog_ok = ~locked | erased_ff;

  ////////////////////////////////////////////////////////////////////
  // erase history: an erase unlocks until the lock bits go from all clear to set again
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      lock_prev_ff <= 1'b0;
    end else begin
      lock_prev_ff <= locked;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      erased_ff <= 1'b0;
    end else if (chip_erase_i) begin
      erased_ff <= 1'b1;
    end else if (locked && !lock_prev_ff) begin
      erased_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // fuse programming with refusal while locked
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      fuse_ff <= `DMC_FUSE_RESET;
    end else if (fuse_prog_i && prog_ok) begin // RQ7
      fuse_ff <= fuse_value_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      refused_ff <= 1'b0;
    end else begin
      refused_ff <= fuse_prog_i & ~prog_ok; // RQ7
    end
  end

  assign debug_enable_fuse_o = fuse_ff;
  assign fuse_refused_o      = refused_ff;

  property p_fuse_refuse;
    @(posedge clock_i) disable iff (!rst_n_i)
      fuse_prog_i && locked && !erased_ff && !chip_erase_i
      |=> $stable(fuse_ff) && refused_ff;
  endproperty
  a_fuse_refuse: assert property (p_fuse_refuse) // RQ7
    else $error("fuse changed while lock bits set without erase");

  property p_fuse_accept;
    @(posedge clock_i) disable iff (!rst_n_i)
      fuse_prog_i && !locked |=> fuse_ff == $past(fuse_value_i) && !refused_ff;
  endproperty
  a_fuse_accept: assert property (p_fuse_accept) // RQ7
    else $error("unlocked fuse program not taken");

endmodule

//--- hw/dmc_pkg.sv
/*
  Types shared by the debug message channel modules.
  Assumes nothing of its surroundings.
*/
package dmc_pkg;

  typedef logic [7:0] dmc_byte_t;
  typedef logic [7:0] dmc_addr_t;

endpackage

//--- hw/dmc_regs.svh
/*
  Constants of the debug message channel: address, field positions,
  reset values and the shared-address option.
  Assumes inclusion by the design files through its bare name.
*/
`ifndef DMC_REGS_SVH
`define DMC_REGS_SVH

// address of the debug channel register in cpu i/o space
`define DMC_CHAN_ADDR      8'h31
// 1: the address is shared with an ordinary i/o register
`define DMC_ADDR_SHARED    1'b1
// dirty flag position in the read value
`define DMC_DIRTY_BIT      7
// low data field of the read value
`define DMC_DATA_MSB       6
`define DMC_CHAN_RESET     8'h00
`define DMC_DIRTY_RESET    1'b0
// debug enable fuse state after reset: unprogrammed
`define DMC_FUSE_RESET     1'b0

`endif
